// ==== verilog/qld_map.svh ====
/*
 * Offsets, field positions, codes and timing counts of the queued read
 * and log read decoder.
 * Assumes a 200 MHz clock; included by bare name.
 */
`ifndef QLD_MAP_SVH
`define QLD_MAP_SVH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define QLD_OP_QREAD     8'h60
`define QLD_OP_LOG_READ  8'h2f
`define QLD_OP_LOG_WRITE 8'h3f

// ----------------------------------------
// Command field positions
// ----------------------------------------
`define QLD_PRIORITY_HI  15
`define QLD_PRIORITY_LO  14
`define QLD_TAG_HI       7
`define QLD_TAG_LO       3
`define QLD_DEV_FORCE    7
`define QLD_DEV_ONE      6
`define QLD_DEV_ZERO     4
`define QLD_DL_COARSE    7

// ----------------------------------------
// Status and error bit positions
// ----------------------------------------
`define QLD_ST_ERR       0
`define QLD_ST_SENSE     1
`define QLD_ST_FAULT     5
`define QLD_ER_ABORT     2
`define QLD_ER_UNC       6

// ----------------------------------------
// Log addresses and sizes
// ----------------------------------------
`define QLD_LOG_DIR      8'h00
`define QLD_LOG_SMART_ER 8'h03
`define QLD_LOG_STATS    8'h04
`define QLD_LOG_SELFTEST 8'h06
`define QLD_LOG_XSELFTST 8'h07
`define QLD_LOG_POWER    8'h08
`define QLD_LOG_PENDING  8'h0c
`define QLD_LOG_CMD_ERR  8'h10
`define QLD_LOG_PHY      8'h11
`define QLD_LOG_NCQ_ND   8'h12
`define QLD_LOG_NCQ_SR   8'h13
`define QLD_LOG_REBUILD  8'h15
`define QLD_LOG_WSTREAM  8'h21
`define QLD_LOG_RSTREAM  8'h22
`define QLD_LOG_CUR_STAT 8'h24
`define QLD_LOG_SAV_STAT 8'h25
`define QLD_LOG_SECTCFG  8'h2f
`define QLD_LOG_IDENT    8'h30
`define QLD_LOG_HOST_LO  8'h80
`define QLD_LOG_HOST_HI  8'h9f
`define QLD_LOG_NAND     8'hd9
`define QLD_HOST_PAGES   17'h00010
`define QLD_OTHER_PAGES  17'h00001

// ----------------------------------------
// Timing
// ----------------------------------------
`define QLD_CLK_NS       200000
`define QLD_MS_NS        1000000
`define QLD_FINE_MS      17'h0000a
`define QLD_COARSE_MS    17'h001f4
`define QLD_FULL_LEN     17'h10000

`endif

// ==== verilog/qld_pkg.sv ====
/*
 * Types of the queued read and log read decoder.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package qld_pkg;
	typedef enum logic [1:0] {
		QLD_IDLE,
		QLD_XFER,
		QLD_DONE
	} qld_state_e;

	typedef enum logic [1:0] {
		QLD_PRIORITY_NORMAL = 2'h0,
		QLD_PRIORITY_ISO    = 2'h1,
		QLD_PRIORITY_HIGH   = 2'h2,
		QLD_PRIORITY_RSVD   = 2'h3
	} qld_priority_e;
endpackage

// ==== verilog/qld_fifo.sv ====
/*
 * Small FIFO between the media/log source and the host data path.
 * Assumes both sides sit on clk_in; read data come from a register.
 */
`timescale 1ns/1ps
module qld_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	input  wire logic             clk_in,
	input  wire logic             rst_in,
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	output logic                  out_valid_out,
	output logic      [WIDTH-1:0] out_data_out,
	input  wire logic             out_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	// Output register refills whenever it is empty or being taken
	assign push = in_valid_in & in_ready_out;
	assign pop  = (cnt_q != '0) & (~out_valid_out | out_ready_in);

	always_ff @(posedge clk_in) begin
		if (push) begin
			mem_q[wr_q] <= in_data_in;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wr_q         <= '0;
			rd_q         <= '0;
			cnt_q        <= '0;
			in_ready_out <= 1'b1;
		end else begin
			if (push) begin
				wr_q <= AW'(wr_q + 1'b1);
			end
			if (pop) begin
				rd_q <= AW'(rd_q + 1'b1);
			end
			cnt_q        <= (AW+1)'(cnt_q + push - pop);
			in_ready_out <= (AW+1)'(cnt_q + push - pop) < (AW+1)'(DEPTH);
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			out_valid_out <= 1'b0;
			out_data_out  <= '0;
		end else if (pop) begin
			out_valid_out <= 1'b1;
			out_data_out  <= mem_q[rd_q];
		end else if (out_ready_in) begin
			out_valid_out <= 1'b0;
		end
	end
endmodule

// ==== verilog/qld_decoder.sv ====
/*
 * Decoder and sequencer for the queued read and the log read commands.
 * Assumes the command source, the media/log source and the host data
 * sink all run on clk_in; one command is sequenced at a time.
 */
`timescale 1ns/1ps
`include "qld_map.svh"

// How it works
// - Opcode 60h requests a sector run from media and streams it to host.
// - An uncorrectable sector stops the read; nothing past it is sent.
// - Queued read length comes from feature; 0000h means 65536 sectors.
// - Count bits 15:14 give priority: 00b normal, 01b deadline, 10b high.
// - High priority is marked urgent; deadline commands are urgent too.
// - Force flag set means data must come from media, not buffer.
// - Force flag clear lets cached data satisfy the read.
// - Deadline code counts only when priority is 01b.
// - An expired deadline is flagged but the command still completes.
// - Fine code: limit is (bits 6:0 plus one) times 10 ms.
// - Coarse code: limit is (bits 6:0 plus one) times 0.5 s.
// - Status bit 1 is sense data, bit 0 error, bit 5 fault on error.
// - Log read returns the log with one interrupt per page block.
// - Log address is LBA 7:0, page LBA 15:8 and 39:32, count from count.
// - Feature field is ignored by the log read.
// - Known logs recognised; only 15h and 80h-9Fh are writable.
// - Log read or write to address 06h is aborted.
// - Abort log access if feature set is off or count or page invalid.
// - Extended self-test log accepted for reads only, while self-test is enabled.
module qld_decoder #(
	parameter int MS_CYCLES = `QLD_MS_NS / (1000000000 / `QLD_CLK_NS / 1000)
) (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        cmd_valid_in,
	input  wire logic [7:0]  cmd_opcode_in,
	input  wire logic [15:0] cmd_feature_in,
	input  wire logic [15:0] cmd_count_in,
	input  wire logic [47:0] cmd_lba_in,
	input  wire logic [7:0]  cmd_completion_deadline_code_in,
	input  wire logic [7:0]  cmd_device_in,
	output logic             cmd_ready_out,
	input  wire logic [4:0]  queue_depth_in,
	input  wire logic        smart_en_in,
	input  wire logic        selftest_en_in,
	input  wire logic        power_cond_en_in,
	input  wire logic        ncq_en_in,
	input  wire logic        rebuild_en_in,
	input  wire logic        stream_en_in,
	input  wire logic        sense_avail_in,
	input  wire logic        fault_in,
	output logic             src_req_out,
	output logic             src_log_out,
	output logic [47:0]      src_lba_out,
	output logic [16:0]      src_len_out,
	output logic             src_force_out,
	output logic             src_urgent_out,
	output logic [1:0]       command_priority_out,
	output logic [4:0]       tag_out,
	input  wire logic        src_valid_in,
	input  wire logic [31:0] src_data_in,
	input  wire logic        src_last_in,
	input  wire logic        src_uncorr_in,
	output logic             src_ready_out,
	output logic             host_valid_out,
	output logic [31:0]      host_data_out,
	input  wire logic        host_ready_in,
	output logic             page_irq_out,
	output logic             deadline_expired_out,
	output logic             done_out,
	output logic [7:0]       status_out,
	output logic [7:0]       error_out
);
	qld_pkg::qld_state_e state_q;
	logic [31:0] busy_q;
	logic [16:0] sect_q;
	logic        stop_q;
	logic        fail_q;
	logic        abort_q;
	logic        irq_q;
	logic [17:0] tick_q;
	logic [16:0] dl_q;
	logic        dl_on_q;
	logic [4:0]  tag;
	logic [7:0]  log_adr;
	logic [15:0] log_page;
	logic        is_q;
	logic        is_log;
	logic        bad;
	logic        push;
	logic        last_sect;
	logic [1:0]  cmd_priority;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [16:0] xfer_len(input logic [15:0] f);
		xfer_len = (f == 16'h0000) ? `QLD_FULL_LEN : {1'b0, f};
	endfunction

	function automatic logic [16:0] limit_ms(input logic [7:0] c);
		logic [16:0] n;
		n = {10'h000, c[6:0]} + 17'h00001;
		limit_ms = c[`QLD_DL_COARSE] ? 17'(n * `QLD_COARSE_MS)
		                              : 17'(n * `QLD_FINE_MS);
	endfunction

	function automatic logic [16:0] log_size(input logic [7:0] a);
		log_size = (a >= `QLD_LOG_HOST_LO && a <= `QLD_LOG_HOST_HI) ?
		           `QLD_HOST_PAGES : `QLD_OTHER_PAGES;
	endfunction

	// Supported and enabled; 06h is never reachable by these commands
	function automatic logic log_ok(input logic [7:0] a);
		case (a)
			`QLD_LOG_DIR, `QLD_LOG_STATS, `QLD_LOG_PENDING,
			`QLD_LOG_CUR_STAT, `QLD_LOG_SAV_STAT, `QLD_LOG_SECTCFG,
			`QLD_LOG_IDENT, `QLD_LOG_PHY, `QLD_LOG_NAND:
				log_ok = 1'b1;
			`QLD_LOG_SMART_ER: log_ok = smart_en_in;
			`QLD_LOG_XSELFTST: log_ok = selftest_en_in;
			`QLD_LOG_POWER:    log_ok = power_cond_en_in;
			`QLD_LOG_CMD_ERR, `QLD_LOG_NCQ_ND, `QLD_LOG_NCQ_SR:
				log_ok = ncq_en_in;
			`QLD_LOG_REBUILD:  log_ok = rebuild_en_in;
			`QLD_LOG_WSTREAM, `QLD_LOG_RSTREAM: log_ok = stream_en_in;
			`QLD_LOG_SELFTEST: log_ok = 1'b0;
			default:
				log_ok = smart_en_in && a >= `QLD_LOG_HOST_LO &&
				         a <= `QLD_LOG_HOST_HI;
		endcase
	endfunction

	function automatic logic log_wr_ok(input logic [7:0] a);
		log_wr_ok = a == `QLD_LOG_REBUILD ||
		            (a >= `QLD_LOG_HOST_LO && a <= `QLD_LOG_HOST_HI);
	endfunction

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	// Feature field is not looked at for log commands
	assign tag      = cmd_count_in[`QLD_TAG_HI:`QLD_TAG_LO];
	assign cmd_priority = cmd_count_in[`QLD_PRIORITY_HI:`QLD_PRIORITY_LO];
	assign log_adr  = cmd_lba_in[7:0];
	assign log_page = {cmd_lba_in[39:32], cmd_lba_in[15:8]};
	assign is_q     = cmd_opcode_in == `QLD_OP_QREAD;
	assign is_log   = cmd_opcode_in == `QLD_OP_LOG_READ ||
	                  cmd_opcode_in == `QLD_OP_LOG_WRITE;

	always_comb begin
		bad = 1'b0;
		if (is_q) begin
			bad = busy_q[tag] || tag > queue_depth_in;
		end else if (is_log) begin
			bad = !log_ok(log_adr) || cmd_count_in == 16'h0000 ||
			      ({1'b0, log_page} + {1'b0, cmd_count_in}) >
			      log_size(log_adr);
			if (cmd_opcode_in == `QLD_OP_LOG_WRITE &&
			    !log_wr_ok(log_adr)) begin
				bad = 1'b1;
			end
		end else begin
			bad = 1'b1;
		end
	end

	assign push      = src_valid_in & src_ready_out & ~stop_q &
	                   ~src_uncorr_in & (state_q == qld_pkg::QLD_XFER);
	assign last_sect = push & src_last_in & (sect_q == src_len_out - 17'h1);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_q        <= qld_pkg::QLD_IDLE;
			cmd_ready_out  <= 1'b1;
			src_req_out    <= 1'b0;
			src_log_out    <= 1'b0;
			src_lba_out    <= '0;
			src_len_out    <= '0;
			src_force_out  <= 1'b0;
			src_urgent_out <= 1'b0;
			command_priority_out <= '0;
			tag_out        <= '0;
			abort_q        <= 1'b0;
		end else begin
			src_req_out <= 1'b0;
			case (state_q)
				qld_pkg::QLD_IDLE: begin
					if (cmd_valid_in) begin
						cmd_ready_out <= 1'b0;
						abort_q       <= bad;
						src_log_out   <= is_log;
						tag_out       <= is_q ? tag : 5'h00;
						command_priority_out <= is_q ? cmd_priority : 2'h0;
						// Cached copies are fine unless forced
						src_force_out <= is_q &
						    cmd_device_in[`QLD_DEV_FORCE];
						// Deadline work rides the urgent hint
						src_urgent_out <= is_q && cmd_priority !=
						    qld_pkg::QLD_PRIORITY_NORMAL;
						if (is_log) begin
							src_lba_out <= {24'h000000, log_page, log_adr};
							src_len_out <= {1'b0, cmd_count_in};
						end else begin
							src_lba_out <= cmd_lba_in;
							src_len_out <= xfer_len(cmd_feature_in);
						end
						src_req_out <= ~bad;
						state_q <= bad ? qld_pkg::QLD_DONE : qld_pkg::QLD_XFER;
					end
				end
				qld_pkg::QLD_XFER: begin
					// Expiry is only flagged, the run carries on
					if (last_sect || stop_q) begin
						state_q <= qld_pkg::QLD_DONE;
					end
				end
				qld_pkg::QLD_DONE: begin
					state_q       <= qld_pkg::QLD_IDLE;
					cmd_ready_out <= 1'b1;
				end
				default: state_q <= qld_pkg::QLD_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Sector count, stop on bad sector
	// ----------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sect_q <= '0;
			stop_q <= 1'b0;
			fail_q <= 1'b0;
			irq_q  <= 1'b0;
		end else if (state_q != qld_pkg::QLD_XFER) begin
			sect_q <= '0;
			stop_q <= 1'b0;
			irq_q  <= 1'b0;
			if (state_q == qld_pkg::QLD_IDLE) begin
				fail_q <= 1'b0;
			end
		end else begin
			irq_q <= push & src_last_in & src_log_out;
			if (push & src_last_in) begin
				sect_q <= 17'(sect_q + 17'h1);
			end
			if (src_valid_in & src_uncorr_in & ~stop_q) begin
				stop_q <= 1'b1;
				fail_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Outstanding tags
	// ----------------------------------------
	// One command runs at a time, so the map mostly guards reuse while done
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			busy_q <= '0;
		end else if (state_q == qld_pkg::QLD_IDLE && cmd_valid_in &&
		             is_q && !bad) begin
			busy_q[tag] <= 1'b1;
		end else if (state_q == qld_pkg::QLD_DONE && !src_log_out &&
		             !abort_q) begin
			busy_q[tag_out] <= 1'b0;
		end
	end

	// ----------------------------------------
	// Deadline timer, 1 ms enable from a divider
	// ----------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			tick_q <= '0;
		end else if (tick_q == 18'(MS_CYCLES - 1)) begin
			tick_q <= '0;
		end else begin
			tick_q <= 18'(tick_q + 18'h1);
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			dl_q                 <= '0;
			dl_on_q              <= 1'b0;
			deadline_expired_out <= 1'b0;
		end else if (state_q == qld_pkg::QLD_IDLE) begin
			deadline_expired_out <= 1'b0;
			dl_on_q <= cmd_valid_in && is_q && !bad &&
			    cmd_priority == qld_pkg::QLD_PRIORITY_ISO;
			dl_q    <= limit_ms(cmd_completion_deadline_code_in);
		end else if (dl_on_q && tick_q == 18'(MS_CYCLES - 1)) begin
			if (dl_q == 17'h00001) begin
				deadline_expired_out <= 1'b1;
				dl_on_q              <= 1'b0;
			end
			dl_q <= 17'(dl_q - 17'h1);
		end
	end

	// ----------------------------------------
	// Completion status
	// ----------------------------------------
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			done_out   <= 1'b0;
			status_out <= '0;
			error_out  <= '0;
		end else begin
			done_out <= state_q == qld_pkg::QLD_DONE;
			if (state_q == qld_pkg::QLD_DONE) begin
				status_out <= '0;
				error_out  <= '0;
				status_out[`QLD_ST_SENSE] <= sense_avail_in;
				status_out[`QLD_ST_ERR]   <= abort_q | fail_q | fault_in;
				status_out[`QLD_ST_FAULT] <= (abort_q | fail_q | fault_in) &
				                             fault_in;
				error_out[`QLD_ER_ABORT]  <= abort_q;
				error_out[`QLD_ER_UNC]    <= fail_q;
			end
		end
	end

	assign page_irq_out = irq_q;

	// ----------------------------------------
	// Data path
	// ----------------------------------------
	qld_fifo #(.WIDTH(32), .DEPTH(4)) u_fifo (
		.clk_in        (clk_in),
		.rst_in        (rst_in),
		.in_valid_in   (push),
		.in_data_in    (src_data_in),
		.in_ready_out  (src_ready_out),
		.out_valid_out (host_valid_out),
		.out_data_out  (host_data_out),
		.out_ready_in  (host_ready_in)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	chk_zero_len: assert property (
		(state_q == qld_pkg::QLD_IDLE && cmd_valid_in && is_q &&
		 cmd_feature_in == 16'h0000) |=> src_len_out == 17'h10000)
		else $error("zero length not taken as 65536");
	chk_stop_bad: assert property (
		stop_q |-> !push)
		else $error("data pushed after bad sector");
	chk_stop_done: assert property (
		(state_q == qld_pkg::QLD_XFER && stop_q) |=>
		state_q == qld_pkg::QLD_DONE ##1 error_out[`QLD_ER_UNC])
		else $error("bad sector not reported");
	chk_log_six: assert property (
		(state_q == qld_pkg::QLD_IDLE && cmd_valid_in && is_log &&
		 log_adr == `QLD_LOG_SELFTEST) |-> ##2 done_out &&
		error_out[`QLD_ER_ABORT] && status_out[`QLD_ST_ERR])
		else $error("log 06h not aborted");
	chk_busy_tag: assert property (
		(state_q == qld_pkg::QLD_IDLE && cmd_valid_in && is_q &&
		 (busy_q[tag] || tag > queue_depth_in)) |=>
		abort_q && !src_req_out)
		else $error("busy tag accepted");
	chk_deadline_gate: assert property (
		(dl_on_q && state_q != qld_pkg::QLD_IDLE) |->
		command_priority_out == qld_pkg::QLD_PRIORITY_ISO)
		else $error("deadline runs for non deadline priority");
	chk_force_bit: assert property (
		(state_q == qld_pkg::QLD_IDLE && cmd_valid_in && is_q) |=>
		src_force_out == $past(cmd_device_in[`QLD_DEV_FORCE]))
		else $error("force flag lost");
	chk_page_irq: assert property (
		(push && src_last_in && src_log_out) |=> page_irq_out)
		else $error("no interrupt for log page");
	chk_err_bit: assert property (
		done_out |-> status_out[`QLD_ST_ERR] ==
		(error_out[`QLD_ER_ABORT] | error_out[`QLD_ER_UNC] |
		 status_out[`QLD_ST_FAULT]))
		else $error("error bit disagrees with error causes");
	chk_fine_lim: assert property (
		(state_q == qld_pkg::QLD_IDLE && cmd_valid_in &&
		 cmd_completion_deadline_code_in == 8'h00) |=> dl_q == 17'h0000a)
		else $error("fine limit wrong");
	chk_coarse_lim: assert property (
		(state_q == qld_pkg::QLD_IDLE && cmd_valid_in &&
		 cmd_completion_deadline_code_in == 8'h80) |=> dl_q == 17'h001f4)
		else $error("coarse limit wrong");

	cov_qread: cover property (src_req_out && !src_log_out);
	cov_log: cover property (page_irq_out);
	cov_abort: cover property (done_out && error_out[`QLD_ER_ABORT]);
	cov_fifo_full: cover property (src_valid_in && !src_ready_out);
endmodule

// ==== tb/qld_src_model.sv ====
/*
 * Media/log source model feeding the decoder's source stream.
 * Assumes clk_in and rst_in of the decoder; one request at a time.
 */
`timescale 1ns/1ps
module qld_src_model #(
	parameter int WPU = 2
) (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        req_in,
	input  wire logic [16:0] len_in,
	input  wire logic [16:0] fail_in,
	input  wire logic        slow_in,
	output logic             valid_out,
	output logic [31:0]      data_out,
	output logic             last_out,
	output logic             uncorr_out,
	input  wire logic        ready_in
);
	logic        act;
	logic [16:0] unit;
	logic [3:0]  wd;
	logic [3:0]  gap;

	// ----------------------------------------
	// Sector or page stream
	// ----------------------------------------
	// Released lines show the inverse of the last word, never a stale copy
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			act <= 1'b0;
			valid_out <= 1'b0;
			{data_out, last_out, uncorr_out} <= '0;
			unit <= '0;
			wd <= '0;
			gap <= '0;
		end else if (req_in) begin
			act <= 1'b1;
			unit <= '0;
			wd <= '0;
			gap <= '0;
		end else if (valid_out) begin
			if (ready_in) begin
				valid_out <= 1'b0;
				{data_out, last_out, uncorr_out} <=
					~{data_out, last_out, uncorr_out};
				gap <= slow_in ? 4'hf : 4'h0;
				wd <= last_out ? 4'h0 : wd + 4'h1;
				if (last_out) begin
					unit <= unit + 17'h1;
					// Nothing follows a failing sector
					if (unit + 17'h1 == len_in || uncorr_out) begin
						act <= 1'b0;
					end
				end
			end
		end else if (gap != 4'h0) begin
			gap <= gap - 4'h1;
		end else if (act) begin
			valid_out <= 1'b1;
			data_out <= 32'(unit) * 32'(WPU) + 32'(wd);
			last_out <= (32'(wd) == WPU - 1);
			uncorr_out <= (unit == fail_in);
		end
	end
endmodule

// ==== tb/tb.sv ====
/*
 * Self-checking bench of the queued read and log read decoder.
 * Assumes the decoder with MS_CYCLES of 4 and a two-word sector model.
 */
`timescale 1ns/1ps
module tb;
	logic        clk_in = 0, rst_in = 1, cmd_valid_in = 0;
	logic [7:0]  cmd_opcode_in = 0, cmd_device_in = 0;
	logic [7:0]  cmd_completion_deadline_code_in = 0;
	logic [15:0] cmd_feature_in = 0, cmd_count_in = 0;
	logic [47:0] cmd_lba_in = 0;
	logic [4:0]  queue_depth_in = 5'h07;
	logic        smart_en_in = 1, sense_avail_in = 0, fault_in = 0;
	logic        selftest_en_in = 1, ncq_en_in = 1;
	logic        host_ready_in = 1, slow = 0;
	logic [16:0] fail = 17'h1ffff;
	logic        cmd_ready_out, src_req_out, src_log_out, src_force_out;
	logic        src_urgent_out, src_valid_in, src_last_in, src_uncorr_in;
	logic        src_ready_out, host_valid_out, page_irq_out, done_out;
	logic        deadline_expired_out;
	logic [47:0] src_lba_out;
	logic [16:0] src_len_out;
	logic [1:0]  command_priority_out;
	logic [4:0]  tag_out;
	logic [31:0] src_data_in, host_data_out;
	logic [7:0]  status_out, error_out, st, er;
	int          miscompares = 0, comparisons = 0;
	int          nw, irqs, cyc, exp_t;

	always #2.5 clk_in = ~clk_in;

	// Feature-set enables not under test stay on
	qld_decoder #(.MS_CYCLES(4)) DUT (.clk_in, .rst_in, .cmd_valid_in,
		.cmd_opcode_in, .cmd_feature_in, .cmd_count_in, .cmd_lba_in,
		.cmd_completion_deadline_code_in, .cmd_device_in,
		.cmd_ready_out, .queue_depth_in, .smart_en_in, .selftest_en_in,
		.power_cond_en_in(1'b1), .ncq_en_in, .rebuild_en_in(1'b1),
		.stream_en_in(1'b1), .sense_avail_in, .fault_in, .src_req_out,
		.src_log_out, .src_lba_out, .src_len_out, .src_force_out,
		.src_urgent_out, .command_priority_out, .tag_out, .src_valid_in,
		.src_data_in, .src_last_in, .src_uncorr_in, .src_ready_out,
		.host_valid_out, .host_data_out, .host_ready_in, .page_irq_out,
		.deadline_expired_out, .done_out, .status_out, .error_out);

	qld_src_model #(.WPU(2)) src (.clk_in, .rst_in, .req_in(src_req_out),
		.len_in(src_len_out), .fail_in(fail), .slow_in(slow),
		.valid_out(src_valid_in), .data_out(src_data_in),
		.last_out(src_last_in), .uncorr_out(src_uncorr_in),
		.ready_in(src_ready_out));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [47:0] got, exp, input string m);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask

	task automatic close_out;
		$display("comparisons %0d miscompares %0d", comparisons,
			miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Host words must arrive in source order
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (host_valid_out === 1'b1 && host_ready_in) begin
			chk(host_data_out, nw, "host word order");
			nw <= nw + 1;
		end
		if (page_irq_out === 1'b1) irqs <= irqs + 1;
		if (deadline_expired_out === 1'b1 && exp_t < 0) exp_t <= cyc;
	end

	// One command, waited on under a bound, then drained
	task automatic issue(input [7:0] op, input [15:0] f, c,
		input [47:0] l, input [7:0] ic, dv);
		int n;
		nw = 0;
		irqs = 0;
		cyc = 0;
		exp_t = -1;
		{cmd_opcode_in, cmd_feature_in, cmd_count_in} = {op, f, c};
		cmd_lba_in = l;
		cmd_completion_deadline_code_in = ic;
		cmd_device_in = dv;
		chk(cmd_ready_out, 1, "not ready");
		cmd_valid_in = 1;
		@(posedge clk_in);
		#1 cmd_valid_in = 0;
		chk(cmd_ready_out, 0, "not taken");
		for (n = 0; n < 3000 && done_out !== 1'b1; n++) begin
			@(posedge clk_in);
			#1;
		end
		chk(n < 3000, 1, "no done");
		{st, er} = {status_out, error_out};
		repeat (12) @(posedge clk_in);
		#1;
	endtask

	task automatic aborted(input string m);
		chk({st[0], er[2]}, 2'b11, m);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		#300000;
		miscompares++;
		close_out;
	end

	// Host stalls so the FIFO fills; device bit 6 set, bit 4 clear
	task automatic t_queued;
		host_ready_in = 0;
		fork
			begin
				repeat (30) @(posedge clk_in);
				#1 chk(src_ready_out, 0, "fifo full");
				host_ready_in = 1;
			end
		join_none
		issue(8'h60, 16'h0004, 16'h8010, 48'h123456789abc, 8'h00, 8'hc0);
		chk(src_lba_out, 48'h123456789abc, "lba");
		chk(src_len_out, 17'h4, "length");
		chk(nw, 8, "words");
		chk({src_force_out, src_urgent_out}, 2'b11, "force");
		chk({command_priority_out, tag_out}, {2'h2, 5'h02},
			"priority tag");
		chk({st, er}, 16'h0000, "ok status");
		issue(8'h60, 16'h0001, 16'h0018, 48'h5, 8'h00, 8'h40);
		chk({src_force_out, src_urgent_out, command_priority_out}, 0,
			"cache");
		chk({tag_out, nw}, {5'h03, 32'd2}, "tag3");
	endtask

	task automatic t_uncorr;
		fail = 17'h0;
		issue(8'h60, 16'h0000, 16'h0020, 48'h0, 8'h00, 8'h40);
		chk(src_len_out, 17'h10000, "full length");
		chk({nw, st[0], er[6]}, {32'd0, 2'b11}, "unc first");
		fail = 17'h1;
		issue(8'h60, 16'h0003, 16'h0020, 48'h0, 8'h00, 8'h40);
		chk({nw, st[0], er[6]}, {32'd2, 2'b11}, "unc mid");
		fail = 17'h1ffff;
	endtask

	task automatic t_deadline;
		slow = 1;
		issue(8'h60, 16'h0003, 16'h4028, 48'h0, 8'h00, 8'h40);
		chk(exp_t >= 38 && exp_t <= 44, 1, "fine limit");
		chk({nw, st}, {32'd6, 8'h00}, "late done");
		issue(8'h60, 16'h0003, 16'h0028, 48'h0, 8'h00, 8'h40);
		chk(exp_t, -48'sd1, "priority 00 no deadline");
		issue(8'h60, 16'h0003, 16'hc028, 48'h0, 8'h00, 8'h40);
		chk(exp_t, -48'sd1, "priority 11 no deadline");
		chk(src_urgent_out, 1, "priority 11 urgent");
		issue(8'h60, 16'h0003, 16'h4028, 48'h0, 8'h80, 8'h40);
		chk(exp_t, -48'sd1, "coarse limit");
		slow = 0;
	endtask

	task automatic t_status;
		issue(8'h60, 16'h0001, 16'h0040, 48'h0, 8'h00, 8'h40);
		aborted("tag over depth");
		{sense_avail_in, fault_in} = 2'b11;
		issue(8'h25, 16'h0001, 16'h0000, 48'h0, 8'h00, 8'h40);
		chk({st[5], st[1], st[0]}, 3'b111, "fault sense");
		{sense_avail_in, fault_in} = 2'b00;
	endtask

	task automatic t_log;
		issue(8'h2f, 16'hffff, 16'h0002, 48'h0e80, 8'h00, 8'h00);
		chk({src_log_out, src_len_out}, {1'b1, 17'h2}, "log");
		chk(src_lba_out, 48'h0e80, "log address");
		chk(irqs, 2, "pages");
		chk({nw, st}, {32'd4, 8'h0}, "page words");
		issue(8'h2f, 16'h0000, 16'h0001, 48'h0001_0000_0080, 8'h0, 8'h0);
		aborted("page high byte");
		selftest_en_in = 0;
		issue(8'h2f, 16'h0000, 16'h0001, 48'h07, 8'h00, 8'h00);
		aborted("self-test off");
		selftest_en_in = 1;
		ncq_en_in = 0;
		issue(8'h2f, 16'h0000, 16'h0001, 48'h10, 8'h00, 8'h00);
		aborted("queue logs off");
		ncq_en_in = 1;
		issue(8'h2f, 16'h0000, 16'h0001, 48'h06, 8'h00, 8'h00);
		aborted("log 06h read");
		issue(8'h3f, 16'h0000, 16'h0001, 48'h06, 8'h00, 8'h00);
		aborted("log 06h write");
		issue(8'h2f, 16'h0000, 16'h0000, 48'h00, 8'h00, 8'h00);
		aborted("count 0");
		smart_en_in = 0;
		issue(8'h2f, 16'h0000, 16'h0001, 48'h03, 8'h00, 8'h00);
		aborted("smart off");
		smart_en_in = 1;
		issue(8'h2f, 16'h0000, 16'h0001, 48'h07, 8'h00, 8'h00);
		chk(st[0], 0, "log 07h");
		issue(8'h3f, 16'h0000, 16'h0001, 48'h15, 8'h00, 8'h00);
		chk(st[0], 0, "write 15h");
		issue(8'h3f, 16'h0000, 16'h0001, 48'h03, 8'h00, 8'h00);
		aborted("write 03h");
	endtask

	initial begin
		repeat (10) @(posedge clk_in);
		#1 rst_in = 0;
		chk({cmd_ready_out, src_ready_out, done_out}, 3'b110, "reset");
		t_queued;
		t_uncorr;
		t_deadline;
		t_status;
		t_log;
		close_out;
	end
endmodule
